// file: test/srw_host_model.sv
// Host model: drives the satellite chip select and shifts in the reply
`timescale 1ns/1ns
module srw_host_model (
    input wire logic clock,
    input wire logic [15:0] reply_word,
    output logic cs_b
);
    // Serial clock stands still outside frames
    logic sclk = 1'b0;
    initial cs_b = 1'b1;
    task automatic xfer(output logic [15:0] w);
        @(posedge clock);
        cs_b <= 1'b0;
        // Offset keeps shift edges clear of the block's clock edges
        #5;
        for (int i = 15; i >= 0; i--) begin
            #40 sclk = 1'b1;
            w[i] = reply_word[i];
            #40 sclk = 1'b0;
        end
        @(posedge clock);
        cs_b <= 1'b1;
        // Leave room for the pop and the three push cycles
        repeat (12) @(posedge clock);
    endtask : xfer
endmodule : srw_host_model

// file: test/srw_reply_framer_test.sv
// Self-checking bench for the satellite reply word framer
`timescale 1ns/1ns
module srw_reply_framer_test;
    import srw_pkg::*;
    logic clock;
    logic rst_b;
    logic cs_b;
    srw_chan_mode_t chan_mode;
    srw_report_t report_sel;
    logic proto_b;
    logic [1:0] b_width_sel;
    logic [12:0] main_config_register;
    logic [12:0] channel_config_register;
    logic flush_req;
    logic bad_bit_count;
    srw_event_t chan_event;
    logic sensor_valid;
    logic [11:0] sensor_data;
    logic [15:0] reply_word;
    logic data_lost_flag;
    logic [15:0] reply_other;
    logic [15:0] w;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    srw_reply_framer #(.FIRST_CHANNEL(1'b1)) dut (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
        .chan_mode(chan_mode), .report_sel(report_sel), .proto_b(proto_b),
        .b_width_sel(b_width_sel), .main_config_register(main_config_register),
        .channel_config_register(channel_config_register), .flush_req(flush_req),
        .bad_bit_count(bad_bit_count), .chan_event(chan_event), .sensor_valid(sensor_valid),
        .sensor_data(sensor_data), .reply_word(reply_word), .data_lost_flag(data_lost_flag));
    // A channel other than the first sees the same traffic
    srw_reply_framer #(.FIRST_CHANNEL(1'b0)) dut_other (.clock(clock), .rst_b(rst_b),
        .cs_b(cs_b), .chan_mode(chan_mode), .report_sel(report_sel), .proto_b(proto_b),
        .b_width_sel(b_width_sel), .main_config_register(main_config_register),
        .channel_config_register(channel_config_register), .flush_req(flush_req),
        .bad_bit_count(bad_bit_count), .chan_event(chan_event), .sensor_valid(sensor_valid),
        .sensor_data(sensor_data), .reply_word(reply_other), .data_lost_flag());
    srw_host_model host (.clock(clock), .reply_word(reply_word), .cs_b(cs_b));

    function automatic logic [15:0] word(input logic [1:0] st, input logic [12:0] body);
        word = {st, ~^{st, body}, body};
    endfunction : word

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [1:0] st, input logic [12:0] body);
        host.xfer(w);
        check("reply", word(st, body), w);
    endtask : chk

    // Queued entries land only at the next chip-select rise
    task automatic put(input logic sv, input logic [11:0] d, input srw_event_t ev);
        @(posedge clock);
        sensor_valid <= sv;
        sensor_data <= d;
        chan_event <= ev;
        @(posedge clock);
        sensor_valid <= 1'b0;
        chan_event <= SRW_EV_NONE;
        host.xfer(w);
    endtask : put

    task automatic code(input logic sv, input logic [11:0] d, input srw_event_t ev,
                        input logic [11:0] exp);
        put(sv, d, ev);
        chk(2'h2, {1'b0, exp});
    endtask : code

    task automatic t_reset;
        repeat (6) @(posedge clock);
        #1;
        check("reset reply", word(2'h3, main_config_register), reply_word);
        check("other reset reply", 16'he000, reply_other);
        @(posedge clock) report_sel <= SRW_REP_CHAN;
        chk(2'h3, channel_config_register);
        $display("reset test done");
    endtask : t_reset

    task automatic t_status;
        @(posedge clock) report_sel <= SRW_REP_FIFO;
        @(posedge clock) chan_mode <= SRW_CH_OFF;
        chk(2'h0, 13'h0000);
        @(posedge clock) chan_mode <= SRW_CH_ON_NOPROC;
        chk(2'h1, 13'h0000);
        @(posedge clock) chan_mode <= SRW_CH_OFF_ALT;
        chk(2'h0, 13'h0000);
        @(posedge clock) chan_mode <= SRW_CH_ON_PROC;
        chk(2'h2, 13'h0000);
        $display("status test done");
    endtask : t_status

    task automatic t_codes;
        code(1'b0, 12'h000, SRW_EV_CUR_LIMIT, 12'h010);
        code(1'b0, 12'h000, SRW_EV_HOST_PAR, 12'h012);
        code(1'b0, 12'h000, SRW_EV_BIT_TIME, 12'h019);
        code(1'b0, 12'h000, SRW_EV_TOO_MANY, 12'h01a);
        code(1'b0, 12'h000, SRW_EV_CRC, 12'h01c);
        code(1'b1, 12'h01f, SRW_EV_NONE, 12'h018);
        code(1'b1, 12'h020, SRW_EV_NONE, 12'h020);
        code(1'b1, 12'hfff, SRW_EV_NONE, 12'hfff);
        put(1'b1, 12'h345, SRW_EV_HOST_PAR);
        chk(2'h2, 13'h0345);
        chk(2'h2, 13'h0012);
        chk(2'h2, 13'h0000);
        put(1'b0, 12'h000, SRW_EV_CUR_LIMIT);
        put(1'b0, 12'h000, SRW_EV_CUR_LIMIT);
        chk(2'h2, 13'h0010);
        $display("code test done");
    endtask : t_codes

    task automatic t_bproto;
        @(posedge clock) proto_b <= 1'b1;
        code(1'b1, 12'hfa5, SRW_EV_NONE, 12'h8a5);
        @(posedge clock) b_width_sel <= 2'h1;
        code(1'b1, 12'hfff, SRW_EV_NONE, 12'h9ff);
        @(posedge clock) b_width_sel <= 2'h3;
        code(1'b1, 12'h2a5, SRW_EV_NONE, 12'haa5);
        code(1'b1, 12'h005, SRW_EV_NONE, 12'h805);
        code(1'b0, 12'h000, SRW_EV_CRC, 12'h01c);
        @(posedge clock) proto_b <= 1'b0;
        $display("b protocol test done");
    endtask : t_bproto

    task automatic t_lost;
        @(posedge clock) report_sel <= SRW_REP_CHAN;
        put(1'b1, 12'h111, SRW_EV_NONE);
        put(1'b1, 12'h222, SRW_EV_NONE);
        check("lost", 16'h0000, {15'h0, data_lost_flag});
        put(1'b1, 12'h333, SRW_EV_NONE);
        check("lost", 16'h0001, {15'h0, data_lost_flag});
        @(posedge clock) report_sel <= SRW_REP_FIFO;
        chk(2'h2, 13'h1111);
        chk(2'h2, 13'h1222);
        chk(2'h2, 13'h1000);
        put(1'b1, 12'h444, SRW_EV_NONE);
        @(posedge clock) flush_req <= 1'b1;
        @(posedge clock) flush_req <= 1'b0;
        repeat (2) @(posedge clock);
        check("lost", 16'h0000, {15'h0, data_lost_flag});
        chk(2'h2, 13'h0000);
        $display("lost test done");
    endtask : t_lost

    task automatic t_global;
        @(posedge clock) bad_bit_count <= 1'b1;
        host.xfer(w);
        #1;
        check("other global", word(2'h2, 13'h0000), reply_other);
        chk(2'h2, 13'h0002);
        chk(2'h2, 13'h0000);
        @(posedge clock) bad_bit_count <= 1'b0;
        $display("global test done");
    endtask : t_global

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Whole run needs about 7000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        rst_b = 1'b0;
        chan_mode = SRW_CH_ON_PROC;
        report_sel = SRW_REP_AUTO;
        proto_b = 1'b0;
        b_width_sel = 2'h0;
        main_config_register = 13'h0a5b;
        channel_config_register = 13'h1c36;
        flush_req = 1'b0;
        bad_bit_count = 1'b0;
        chan_event = SRW_EV_NONE;
        sensor_valid = 1'b0;
        sensor_data = 12'h000;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_status();
        t_codes();
        t_bproto();
        t_lost();
        t_global();
        conclude();
    end
endmodule : srw_reply_framer_test

// file: verilog/srw_cfg.svh
// Constants for the satellite reply word framer
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
`define SRW_ST_HI 15
`define SRW_ST_LO 14
`define SRW_PAR_BIT 13
`define SRW_LOST_BIT 12
`define SRW_CFG_REPORT 2'h3
`define SRW_IDLE_REPLY 16'he000
`define SRW_EMPTY_VAL 12'h000
`define SRW_GF_BAD_COUNT 12'h002
`define SRW_CF_CUR_LIMIT 12'h010
`define SRW_CF_HOST_PAR 12'h012
`define SRW_CF_RESERVED 12'h018
`define SRW_CF_BIT_TIME 12'h019
`define SRW_CF_TOO_MANY 12'h01a
`define SRW_CF_CRC 12'h01c
`define SRW_A_DATA_MIN 12'h020
`define SRW_B_DATA_FLAG 12'h800
`define SRW_FIFO_DEPTH 2
`endif

// file: verilog/srw_fifo.sv
// Two-entry reply FIFO with flush and data-lost flag
`timescale 1ns/1ns
`include "srw_cfg.svh"
module srw_fifo (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic push,
    input wire logic [11:0] push_word,
    input wire logic pop,
    output logic [11:0] head_word,
    output logic empty,
    output logic lost
);
    import srw_pkg::*;
    logic [11:0] mem [0:`SRW_FIFO_DEPTH-1];
    logic [1:0] count;
    logic full;
    logic do_pop;

    assign full = (count == 2'(`SRW_FIFO_DEPTH));
    assign empty = (count == 2'h0);
    assign do_pop = pop && !empty;
    assign head_word = empty ? `SRW_EMPTY_VAL : mem[0];

    always_ff @(posedge clock) begin
        if (!rst_b || flush) begin
            count <= 2'h0;
        end else if (push && !full && !do_pop) begin
            count <= count + 2'h1;
        end else if (do_pop && !push) begin
            // A pop together with a push keeps the count; the entries shift
            count <= count - 2'h1;
        end
    end

    // Entry 0 is always the oldest; pop shifts the second entry down
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mem[0] <= 12'h000;
            mem[1] <= 12'h000;
        end else if (!flush) begin
            if (do_pop) begin
                mem[0] <= (push && count == 2'h1) ? push_word : mem[1];
                if (push && count == 2'h2) begin
                    mem[1] <= push_word;
                end
            end else if (push && !full) begin
                mem[count[0]] <= push_word;
            end
        end
    end

    // Sticky until the host flushes; a word pushed when full with no pop is dropped
    always_ff @(posedge clock) begin
        if (!rst_b || flush) begin
            lost <= 1'b0;
        end else if (push && full && !do_pop) begin
            lost <= 1'b1;
        end
    end

    a_fifo_overflow: assert property (@(posedge clock) disable iff (!rst_b)
        (push && full && !do_pop && !flush) |=> lost)
        else $error("lost flag not set on overflow");
    a_fifo_flush: assert property (@(posedge clock) disable iff (!rst_b)
        flush |=> empty && !lost)
        else $error("flush did not empty the fifo");
endmodule : srw_fifo

// file: verilog/srw_pkg.sv
// Types for the satellite reply word framer
package srw_pkg;
    typedef enum logic [1:0] {
        SRW_CH_OFF = 2'h0,
        SRW_CH_ON_NOPROC = 2'h1,
        SRW_CH_ON_PROC = 2'h3,
        SRW_CH_OFF_ALT = 2'h2
    } srw_chan_mode_t;
    typedef enum logic [1:0] {
        SRW_REP_AUTO = 2'h0,
        SRW_REP_MAIN = 2'h1,
        SRW_REP_CHAN = 2'h2,
        SRW_REP_FIFO = 2'h3
    } srw_report_t;
    typedef enum logic [2:0] {
        SRW_EV_NONE = 3'h0,
        SRW_EV_CUR_LIMIT = 3'h1,
        SRW_EV_HOST_PAR = 3'h2,
        SRW_EV_BIT_TIME = 3'h3,
        SRW_EV_TOO_MANY = 3'h4,
        SRW_EV_CRC = 3'h5
    } srw_event_t;
endpackage : srw_pkg

// file: verilog/srw_reply_framer.sv
// Reply word framer for one satellite channel
// Behaviour
// - Status bits refresh on chip-select fall
// - Queue and pop FIFO on chip-select rise
// - Fault codes live in range 001 to 01F
// - Channel fault per occurrence, global once
// - Bit 13 makes the word odd parity
// - Data reply: lost flag, twelve data bits
// - Write into full FIFO sets lost flag
// - Status pair encodes channel mode or report
// - Empty FIFO, no fault returns zero contents
// - Bad bit count: global code 2, channel one
// - Current limit 10, host parity error 12
// - A protocol: 19 bit time, 1A many, 1C CRC
// - A data below 020 raises fault 18
// - B protocol: bit 11 set for data
// - B protocol: parity fail 1C, 18 unused
// - B data right-justified by configured width
// - After reset, channel one main, others E000
// - Two entries; flush discards both
`timescale 1ns/1ns
`include "srw_cfg.svh"
module srw_reply_framer #(
    parameter logic FIRST_CHANNEL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire srw_pkg::srw_chan_mode_t chan_mode,
    input wire srw_pkg::srw_report_t report_sel,
    input wire logic proto_b,
    input wire logic [1:0] b_width_sel,
    input wire logic [12:0] main_config_register,
    input wire logic [12:0] channel_config_register,
    input wire logic flush_req,
    input wire logic bad_bit_count,
    input wire srw_pkg::srw_event_t chan_event,
    input wire logic sensor_valid,
    input wire logic [11:0] sensor_data,
    output logic [15:0] reply_word,
    output logic data_lost_flag
);
    import srw_pkg::*;

    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic cs_fall;
    logic cs_rise;
    logic status_high_bit;
    logic status_low_bit;
    logic [1:0] next_status;
    logic [1:0] frame_status;
    logic global_latched;
    logic [11:0] pend_fault;
    logic pend_global;
    logic [11:0] pend_data;
    logic pend_data_v;
    logic [1:0] push_phase;
    logic push;
    logic [11:0] push_word;
    logic pop;
    logic [11:0] head_word;
    logic fifo_empty;
    logic lost;
    logic [11:0] event_code;
    logic [11:0] shaped_data;
    logic [11:0] b_mask;
    logic [14:0] next_body;
    logic next_par;

    // Chip select comes from the host pins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_b;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end
    assign cs_fall = cs_prev && !cs_sync;
    assign cs_rise = !cs_prev && cs_sync;

    always_comb begin
        if (report_sel != SRW_REP_FIFO) begin
            next_status = `SRW_CFG_REPORT;
        end else begin
            case (chan_mode)
                SRW_CH_ON_NOPROC: next_status = 2'h1;
                SRW_CH_ON_PROC: next_status = 2'h2;
                default: next_status = 2'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_high_bit <= 1'b1;
            status_low_bit <= 1'b1;
        end else if (cs_fall) begin
            {status_high_bit, status_low_bit} <= next_status;
        end
    end
    // Reply reloads every deselected cycle and last at the fall, so the frame carries fresh status
    assign frame_status = cs_fall ? next_status : {status_high_bit, status_low_bit};

    always_comb begin
        case (chan_event)
            SRW_EV_CUR_LIMIT: event_code = `SRW_CF_CUR_LIMIT;
            SRW_EV_HOST_PAR: event_code = `SRW_CF_HOST_PAR;
            SRW_EV_BIT_TIME: event_code = `SRW_CF_BIT_TIME;
            SRW_EV_TOO_MANY: event_code = `SRW_CF_TOO_MANY;
            SRW_EV_CRC: event_code = `SRW_CF_CRC;
            default: event_code = `SRW_EMPTY_VAL;
        endcase
    end

    // B data: keep configured width 8..11, then flag bit 11
    assign b_mask = 12'h0ff | {1'b0, (b_width_sel == 2'h3), (b_width_sel[1]), (|b_width_sel), 8'h00};
    always_comb begin
        if (proto_b) begin
            shaped_data = (sensor_data & b_mask & 12'h7ff) | `SRW_B_DATA_FLAG;
        end else if (sensor_data < `SRW_A_DATA_MIN) begin
            shaped_data = `SRW_CF_RESERVED;
        end else begin
            shaped_data = sensor_data;
        end
    end

    // Pending events gather between frames; one latch per kind
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pend_fault <= 12'h000;
            pend_data <= 12'h000;
            pend_data_v <= 1'b0;
            pend_global <= 1'b0;
            global_latched <= 1'b0;
        end else begin
            if (chan_event != SRW_EV_NONE) begin
                pend_fault <= event_code;
            end else if (push_phase == 2'h1) begin
                pend_fault <= 12'h000;
            end
            if (sensor_valid) begin
                pend_data <= shaped_data;
                pend_data_v <= 1'b1;
            end else if (push_phase == 2'h2) begin
                pend_data_v <= 1'b0;
            end
            if (FIRST_CHANNEL && bad_bit_count && !global_latched) begin
                pend_global <= 1'b1;
                global_latched <= 1'b1;
            end else if (push_phase == 2'h3) begin
                pend_global <= 1'b0;
            end
            if (!bad_bit_count && !pend_global) begin
                global_latched <= 1'b0;
            end
        end
    end

    // Rise: pop reported head, then push global, data, fault in order
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            push_phase <= 2'h0;
        end else if (cs_rise) begin
            push_phase <= 2'h3;
        end else if (push_phase != 2'h0) begin
            push_phase <= push_phase - 2'h1;
        end
    end
    assign pop = cs_rise && report_sel == SRW_REP_FIFO;
    always_comb begin
        case (push_phase)
            2'h3: begin push = pend_global; push_word = `SRW_GF_BAD_COUNT; end
            2'h2: begin push = pend_data_v; push_word = pend_data; end
            2'h1: begin push = pend_fault != 12'h000; push_word = pend_fault; end
            default: begin push = 1'b0; push_word = 12'h000; end
        endcase
    end

    srw_fifo u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .flush(flush_req),
        .push(push),
        .push_word(push_word),
        .pop(pop),
        .head_word(head_word),
        .empty(fifo_empty),
        .lost(lost)
    );

    always_comb begin
        case (report_sel)
            SRW_REP_FIFO: next_body = {frame_status, lost, head_word};
            SRW_REP_CHAN: next_body = {2'h3, channel_config_register};
            default: next_body = FIRST_CHANNEL ? {2'h3, main_config_register}
                                               : 15'h6000;
        endcase
        next_par = ~(^next_body);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            // Odd-parity idle word; channel one loads its main report right after
            reply_word <= `SRW_IDLE_REPLY;
            data_lost_flag <= 1'b0;
        end else if (cs_sync || cs_fall) begin
            reply_word <= {next_body[14:13], next_par, next_body[12:0]};
            data_lost_flag <= lost;
        end
    end

    a_parity_odd: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> ^reply_word)
        else $error("reply word parity is not odd");
    a_fault_range: assert property (@(posedge clock) disable iff (!rst_b)
        pend_fault <= 12'h01f)
        else $error("fault code outside reserved range");
    a_status_frame: assert property (@(posedge clock) disable iff (!rst_b)
        cs_fall && report_sel == SRW_REP_FIFO
        |=> reply_word[15:14] == {status_high_bit, status_low_bit})
        else $error("frame reply lacks fresh status");
    a_status_fall: assert property (@(posedge clock) disable iff (!rst_b)
        cs_fall && report_sel == SRW_REP_FIFO && chan_mode == SRW_CH_ON_PROC
        |=> {status_high_bit, status_low_bit} == 2'h2)
        else $error("status not updated on chip select fall");
    a_push_order: assert property (@(posedge clock) disable iff (!rst_b)
        cs_rise |=> push_phase == 2'h3 ##1 push_phase == 2'h2 ##1 push_phase == 2'h1)
        else $error("push sequence out of order");
    a_global_once: assert property (@(posedge clock) disable iff (!rst_b)
        global_latched && bad_bit_count |=> global_latched)
        else $error("global fault relatched");
    a_empty_zero: assert property (@(posedge clock) disable iff (!rst_b)
        fifo_empty |-> head_word == `SRW_EMPTY_VAL)
        else $error("empty fifo not reported as zero");
    a_b_flag: assert property (@(posedge clock) disable iff (!rst_b)
        proto_b |-> shaped_data[11])
        else $error("B data flag bit clear");
    a_a_reserved: assert property (@(posedge clock) disable iff (!rst_b)
        !proto_b && sensor_data < 12'h020 |-> shaped_data == 12'h018)
        else $error("reserved A data not flagged");
    a_lost_out: assert property (@(posedge clock) disable iff (!rst_b)
        cs_sync && $rose(lost) |=> data_lost_flag)
        else $error("lost flag not reported");
endmodule : srw_reply_framer
